/* core/txd_engine.sv */
// transmit descriptor engine: fetch, ownership check, byte stream, status write-back
// assumes an APB master, a single-outstanding word memory port and a MAC on mclk
//
// The implementer's own choices: the register addresses and the APB interface to the registers.

module txd_engine
  import txd_pkg::*;
#(
  parameter int unsigned APB_AW = 8
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  input wire logic mac_done,
  input txd_stat_s mac_stat,
  output logic irq
);

  txd_regs_s r;
  txd_regs_s n;
  logic [7:0] addr8;
  logic setup;
  logic wr_acc;
  logic hit;
  logic [31:0] rd_mux;
  logic [TBS_W-1:0] tbs1;
  logic [TBS_W-1:0] tbs2;
  logic last_seg;
  txd_state_e fin_st;
  txd_stat_s wb_stat;
  logic [31:0] wb_word;
  logic wb_err;
  logic poll;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] w1c;

  // ****************************************
  // register bus
  // ****************************************
  assign addr8 = paddr[7:0];
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign pready = 1'b1;
  assign prdata = r.prdata;
  assign pslverr = psel & penable & ~hit;

  always_comb
  begin
    hit = 1'b1;
    rd_mux = '0;
    unique case (addr8)
      REG_CTRL: rd_mux[CTRL_RUN] = r.run;
      REG_BASE: rd_mux = r.base;
      REG_CUR: rd_mux = r.cur;
      REG_STATE: rd_mux[2:0] = r.st;
      REG_ISTAT: rd_mux[IRQ_W-1:0] = r.ist;
      REG_IMASK: rd_mux[IRQ_W-1:0] = r.imask;
      default: hit = 1'b0;
    endcase
  end

  // ****************************************
  // descriptor fields
  // ****************************************
  assign tbs1 = r.ctl[TBS1_LSB +: TBS_W];
  assign tbs2 = r.ctl[TBS2_LSB +: TBS_W];
  assign last_seg = r.ctl[LAST_SEG_BIT];
  // only the last segment waits for the MAC verdict
  assign fin_st = last_seg ? ST_WAITMAC : ST_WB;
  assign wb_stat = last_seg ? r.stat : '0;

  txd_wb_pack u_pack (
    .stat(wb_stat),
    .word0(wb_word),
    .err(wb_err)
  );

  txd_byte_pick u_pick (
    .word(r.word),
    .lane(r.p[1:0]),
    .byte_out(tx_data)
  );

  // ****************************************
  // memory and stream ports
  // ****************************************
  assign mem_req = (r.st == ST_FETCH) | (r.st == ST_RDW) | (r.st == ST_WB);
  assign mem_we = (r.st == ST_WB);
  assign mem_wdata = wb_word;
  // buffer words are read aligned; the lane picks the byte
  always_comb
  begin
    if (r.st == ST_FETCH)
      mem_addr = r.cur + {28'h0, r.idx, 2'h0};
    else if (r.st == ST_WB)
      mem_addr = r.cur;
    else
      mem_addr = {r.p[31:2], 2'h0};
  end

  assign tx_valid = (r.st == ST_EMIT);
  assign tx_last = tx_valid & last_seg & (r.cnt == 11'h1) & (r.seg | tbs2 == '0);
  assign irq = |(r.ist & r.imask);

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    n = r;
    poll = 1'b0;
    ev = '0;
    w1c = '0;
    if (setup)
      n.prdata = rd_mux;
    if (wr_acc)
    begin
      unique case (addr8)
        REG_CTRL:
        begin
          n.run = pwdata[CTRL_RUN];
          poll = pwdata[CTRL_POLL];
        end
        // low bits dropped: descriptors sit on 16-byte blocks
        REG_BASE: n.base = {pwdata[31:4], 4'h0};
        REG_ISTAT: w1c = pwdata[IRQ_W-1:0];
        REG_IMASK: n.imask = pwdata[IRQ_W-1:0];
        default: n.run = r.run;
      endcase
    end

    unique case (r.st)
      ST_STOP:
        if (r.run)
        begin
          n.cur = r.base;
          n.idx = '0;
          n.st = ST_FETCH;
        end
      ST_FETCH:
        if (mem_ack)
        begin
          n.idx = r.idx + 2'h1;
          unique case (r.idx)
            2'h0:
              // an unowned descriptor is left alone
              if (!mem_rdata[OWN_BIT])
              begin
                n.st = ST_SUSP;
                ev[IRQ_SUSP] = 1'b1;
              end
            2'h1: n.ctl = mem_rdata;
            2'h2: n.p = mem_rdata;
            2'h3:
            begin
              n.ptr2 = mem_rdata;
              // an empty buffer is skipped
              if (tbs1 != '0)
              begin
                n.cnt = tbs1;
                n.seg = 1'b0;
                n.st = ST_RDW;
              end
              else if (tbs2 != '0)
              begin
                n.p = mem_rdata;
                n.cnt = tbs2;
                n.seg = 1'b1;
                n.st = ST_RDW;
              end
              else
                n.st = fin_st;
            end
          endcase
        end
      ST_SUSP:
        if (!r.run)
          n.st = ST_STOP;
        else if (poll)
        begin
          n.idx = '0;
          n.st = ST_FETCH;
        end
      ST_RDW:
        if (mem_ack)
        begin
          n.word = mem_rdata;
          n.st = ST_EMIT;
        end
      ST_EMIT:
        if (tx_ready)
        begin
          n.p = r.p + 32'h1;
          n.cnt = r.cnt - 11'h1;
          if (r.cnt == 11'h1)
          begin
            if (!r.seg && tbs2 != '0)
            begin
              n.p = r.ptr2;
              n.cnt = tbs2;
              n.seg = 1'b1;
              n.st = ST_RDW;
            end
            else
              n.st = fin_st;
          end
          else if (r.p[1:0] == 2'h3)
            n.st = ST_RDW;
        end
      ST_WAITMAC:
        if (r.mac_seen)
          n.st = ST_WB;
      ST_WB:
        if (mem_ack)
        begin
          // ownership returns with the status in this single write
          n.mac_seen = 1'b0;
          ev[IRQ_DONE] = 1'b1;
          ev[IRQ_ERR] = wb_err;
          n.cur = r.ctl[END_RING_BIT] ? r.base : r.cur + DESC_BYTES;
          n.idx = '0;
          n.st = r.run ? ST_FETCH : ST_STOP;
        end
    endcase

    // a verdict arriving while the old one is retired still counts
    if (mac_done)
    begin
      n.stat = mac_stat;
      n.mac_seen = 1'b1;
    end
    // a new event beats a clear in the same cycle
    n.ist = (r.ist & ~w1c) | ev;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      r <= '0;
      r.st <= ST_STOP;
    end
    else
      r <= n;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_wb_own_clear:
    assert property (mem_req && mem_we |-> !mem_wdata[OWN_BIT])
    else $error("write-back leaves ownership set");

  a_wb_single:
    assert property (r.st == ST_WB && mem_ack |=> r.st != ST_WB && !mem_req || !mem_we)
    else $error("status written more than once");

  a_rsvd_zero:
    assert property (mem_we |-> mem_wdata[30:16] == '0 && mem_wdata[14:12] == '0)
    else $error("reserved status bits not zero");

  a_err_summary:
    assert property (mem_we |-> mem_wdata[ERROR_SUMMARY_BIT] ==
                     |{mem_wdata[CARRIER_LOST_BIT:EXCESSIVE_COLLISION_BIT],
                       mem_wdata[EXCESSIVE_DEFERRAL_BIT]})
    else $error("error summary mismatch");

  a_susp_entry:
    assert property (r.st == ST_FETCH && r.idx == 2'h0 && mem_ack && !mem_rdata[OWN_BIT]
                     |=> r.st == ST_SUSP ##1 r.ist[IRQ_SUSP])
    else $error("unowned descriptor not suspended");

  a_stat_capture:
    assert property (mac_done |=> r.stat == $past(mac_stat) && r.mac_seen)
    else $error("transmit verdict not captured");

  a_byte_lane:
    assert property (tx_valid && tx_ready && r.cnt > 11'h1 && r.p[1:0] != 2'h3
                     |=> tx_valid && r.cnt == $past(r.cnt) - 11'h1 && r.p[1:0] != 2'h0)
    else $error("byte walk broken");

  a_desc_align:
    assert property (r.st == ST_FETCH |-> mem_addr[1:0] == 2'h0 && r.cur[3:0] == 4'h0)
    else $error("descriptor fetch misaligned");

  a_irq_sticky:
    assert property (r.ist[IRQ_DONE] && !(wr_acc && addr8 == REG_ISTAT && pwdata[IRQ_DONE])
                     |=> r.ist[IRQ_DONE])
    else $error("done flag lost");

  a_susp_idle:
    assert property (r.st == ST_SUSP |-> !mem_req && !tx_valid)
    else $error("suspended engine still active");

  a_tx_hold:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("stalled byte changed");

  a_wait_verdict:
    assert property (r.st == ST_WAITMAC && !r.mac_seen |=> !mem_we)
    else $error("status written before verdict");

  a_own_open:
    assert property (r.st == ST_FETCH && r.idx == 2'h0 && mem_ack && mem_rdata[OWN_BIT]
                     |=> r.st == ST_FETCH && r.idx == 2'h1)
    else $error("owned descriptor not opened");

endmodule

/* pkg/txd_pkg.sv */
// shared constants and types of the transmit descriptor engine
// assumes one clock domain; descriptors live in host memory reached word by word

package txd_pkg;

  // ****************************************
  // descriptor layout
  // ****************************************
  localparam int unsigned OWN_BIT = 31;
  localparam int unsigned ERROR_SUMMARY_BIT = 15;
  localparam int unsigned CARRIER_LOST_BIT = 11;
  localparam int unsigned NC_BIT = 10;
  localparam int unsigned LATE_COLLISION_BIT = 9;
  localparam int unsigned EXCESSIVE_COLLISION_BIT = 8;
  localparam int unsigned CC_LSB = 3;
  localparam int unsigned CC_W = 4;
  localparam int unsigned EXCESSIVE_DEFERRAL_BIT = 2;
  localparam int unsigned DE_BIT = 0;
  localparam int unsigned TBS_W = 11;
  localparam int unsigned TBS1_LSB = 0;
  localparam int unsigned TBS2_LSB = 11;
  localparam int unsigned END_RING_BIT = 25;
  localparam int unsigned LAST_SEG_BIT = 30;
  localparam logic [31:0] DESC_BYTES = 32'h10;
  localparam logic [3:0] DESC_ALIGN_MASK = 4'hF;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BASE = 8'h04;
  localparam logic [7:0] REG_CUR = 8'h08;
  localparam logic [7:0] REG_STATE = 8'h0C;
  localparam logic [7:0] REG_ISTAT = 8'h10;
  localparam logic [7:0] REG_IMASK = 8'h14;
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_POLL = 1;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_SUSP = 1;
  localparam int unsigned IRQ_ERR = 2;

  typedef enum logic [2:0] {
    ST_STOP,
    ST_FETCH,
    ST_SUSP,
    ST_RDW,
    ST_EMIT,
    ST_WAITMAC,
    ST_WB
  } txd_state_e;

  typedef struct packed {
    logic carrier_lost_flag;
    logic nc;
    logic late_collision_flag;
    logic excessive_collision_flag;
    logic [CC_W-1:0] cc;
    logic excessive_deferral_flag;
    logic de;
  } txd_stat_s;

  typedef struct packed {
    txd_state_e st;
    logic run;
    logic [31:0] base;
    logic [31:0] cur;
    logic [31:0] ctl;
    logic [31:0] ptr2;
    logic [31:0] p;
    logic [31:0] word;
    logic [TBS_W-1:0] cnt;
    logic seg;
    logic [1:0] idx;
    txd_stat_s stat;
    logic mac_seen;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imask;
    logic [31:0] prdata;
  } txd_regs_s;

endpackage

/* core/txd_byte_pick.sv */
// picks one byte lane out of a fetched memory word
// assumes little-endian lane order, lane 0 in bits 7:0

module txd_byte_pick
  import txd_pkg::*;
(
  input wire logic [31:0] word,
  input wire logic [1:0] lane,
  output logic [7:0] byte_out
);

  always_comb
  begin
    unique case (lane)
      2'h0: byte_out = word[7:0];
      2'h1: byte_out = word[15:8];
      2'h2: byte_out = word[23:16];
      2'h3: byte_out = word[31:24];
    endcase
  end

endmodule

/* core/txd_wb_pack.sv */
// builds the status word written back to a closed descriptor
// assumes the caller writes the result in one memory write

module txd_wb_pack
  import txd_pkg::*;
(
  input txd_stat_s stat,
  output logic [31:0] word0,
  output logic err
);

  always_comb
  begin
    // reserved bits and ownership stay zero
    word0 = '0;
    err = stat.excessive_deferral_flag | stat.excessive_collision_flag
      | stat.late_collision_flag | stat.nc | stat.carrier_lost_flag;
    word0[ERROR_SUMMARY_BIT] = err;
    word0[CARRIER_LOST_BIT] = stat.carrier_lost_flag;
    word0[NC_BIT] = stat.nc;
    word0[LATE_COLLISION_BIT] = stat.late_collision_flag;
    word0[EXCESSIVE_COLLISION_BIT] = stat.excessive_collision_flag;
    word0[CC_LSB +: CC_W] = stat.cc;
    word0[EXCESSIVE_DEFERRAL_BIT] = stat.excessive_deferral_flag;
    word0[DE_BIT] = stat.de;
  end

endmodule

/* test/txd_mem_model.sv */
// host memory model: descriptor ring and frame buffers behind the word port
// assumes byte addresses below 256; the bench picks the answer latency
module txd_mem_model
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [1:0] lat,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // storage and handshake
  // ****************************************
  logic [31:0] mem [64];
  logic [1:0] wait_q;
  assign mem_ack = mem_req && (wait_q == lat);
  // without ack the line shows the inverse, so a stale word never looks right
  assign mem_rdata = mem_ack ? mem[mem_addr[7:2]] : ~mem[mem_addr[7:2]];
  always @(posedge mclk)
  begin
    if (!rst_b || !mem_req || mem_ack)
      wait_q <= 2'h0;
    else
      wait_q <= wait_q + 2'h1;
    // the port changes memory only on an acknowledged write; the bench also writes it directly
    if (mem_ack && mem_we)
      mem[mem_addr[7:2]] <= mem_wdata;
  end
endmodule

/* test/tb.sv */
// self-checking bench: APB setup, descriptor hand-over, byte stream, write-back
// assumes the memory model holds one ring entry that ends the ring
module tb import txd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr, tx_data;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata;
  logic mem_req, mem_we, mem_ack, tx_valid, tx_last, tx_ready, mac_done, last_seen;
  logic [1:0] lat;
  txd_stat_s mac_stat;
  logic [7:0] got [$];
  logic [9:0] pat [6];
  logic [7:0] exp_b [5];
  int mismatches, comparisons;

  txd_engine txd_engine_inst (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .mac_done(mac_done),
    .mac_stat(mac_stat), .irq(irq));
  txd_mem_model txd_mem_model_inst (.mclk(mclk), .rst_b(rst_b), .lat(lat),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    // stalling every other cycle tests that tx_data holds
    tx_ready <= ~tx_ready;
    if (tx_valid && tx_ready)
    begin
      got.push_back(tx_data);
      if (tx_last)
        last_seen = 1'b1;
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    check(rd, exp);
  endtask
  task results;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task t_unmapped;
    logic [31:0] rd;
    logic e;
    apb(1'b0, 8'h20, 32'h0, rd, e);
    check({31'h0, e}, 32'h1);
    check(rd, 32'h0);
  endtask
  task t_frame(input txd_stat_s s, input int i);
    logic [31:0] w, rd;
    logic err_sum, e;
    int n;
    err_sum = s.excessive_deferral_flag | s.excessive_collision_flag;
    err_sum = err_sum | s.late_collision_flag | s.nc | s.carrier_lost_flag;
    w = {16'h0, err_sum, 3'h0, s.carrier_lost_flag, s.nc, s.late_collision_flag,
      s.excessive_collision_flag, 1'b0, s.cc, s.excessive_deferral_flag, 1'b0, s.de};
    got.delete();
    last_seen = 1'b0;
    lat <= 2'(i % 3);
    txd_mem_model_inst.mem[0] = 32'h8000_0000;
    wr(REG_CTRL, (i == 0) ? 32'h1 : 32'h3);
    for (n = 0; n < 300 && !last_seen; n++)
      @(posedge mclk);
    @(posedge mclk);
    mac_done <= 1'b1;
    mac_stat <= s;
    @(posedge mclk);
    mac_done <= 1'b0;
    check(32'(got.size()), 32'h5);
    for (n = 0; n < 5 && n < got.size(); n++)
      check({24'h0, got[n]}, {24'h0, exp_b[n]});
    for (n = 0; n < 300 && txd_mem_model_inst.mem[0][OWN_BIT] !== 1'b0; n++)
      @(posedge mclk);
    check(txd_mem_model_inst.mem[0], w);
    rd = 32'h0;
    for (n = 0; n < 50 && rd !== 32'h2; n++)
      apb(1'b0, REG_STATE, 32'h0, rd, e);
    check(rd, 32'h2);
    rd_chk(REG_ISTAT, {29'h0, err_sum, 2'h3});
    if (i == 0)
    begin
      check({31'h0, irq}, 32'h0);
      wr(REG_IMASK, 32'h7);
      // the mask lands on the access edge and irq with it; the bench samples one edge later
      @(posedge mclk);
    end
    check({31'h0, irq}, 32'h1);
    wr(REG_ISTAT, 32'h7);
    rd_chk(REG_ISTAT, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask

  initial
  begin
    mclk = 1'b0;
    rst_b = 1'b0;
    {psel, penable, pwrite, tx_ready, mac_done, last_seen} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    lat = 2'h0;
    mac_stat = '0;
    pat = '{10'h015, 10'h002, 10'h040, 10'h080, 10'h100, 10'h200};
    exp_b = '{8'h22, 8'h33, 8'h44, 8'h88, 8'h99};
    for (int k = 0; k < 64; k++)
      txd_mem_model_inst.mem[k] = 32'h0;
    // last segment, end of ring, buffer sizes 3 and 2, odd first pointer
    txd_mem_model_inst.mem[1] = 32'h4200_1003;
    txd_mem_model_inst.mem[2] = 32'h0000_0041;
    txd_mem_model_inst.mem[3] = 32'h0000_0050;
    txd_mem_model_inst.mem[16] = 32'h4433_2211;
    txd_mem_model_inst.mem[20] = 32'hBBAA_9988;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    t_unmapped();
    wr(REG_BASE, 32'h0000_000F);
    rd_chk(REG_BASE, 32'h0);
    for (int i = 0; i < 6; i++)
      t_frame(txd_stat_s'(pat[i]), i);
    results();
  end
  initial
  begin
    #200000;
    mismatches++;
    results();
  end
endmodule
